/* hdl/tmr8_pkg.sv */
// package: register map, field positions, mode codes and timing counts of the 8-bit timer
package tmr8_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [11:0] ADDR_CTRL_A = 12'h000;
    localparam logic [11:0] ADDR_COUNT = 12'h004;
    localparam logic [11:0] ADDR_COMPARE = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h010;
    localparam logic [11:0] ADDR_GEN_CTRL = 12'h014;
    localparam logic [11:0] ADDR_PORT_CTRL = 12'h018;
    // control a field positions
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_WAVE1_BIT = 6;
    localparam int CTRL_OUT_LSB = 4;
    localparam int CTRL_WAVE0_BIT = 3;
    localparam int CTRL_CS_LSB = 0;
    // flag / mask bit positions
    localparam int FLAG_CMP_BIT = 1;
    localparam int FLAG_OVF_BIT = 0;
    // general control bits
    localparam int GEN_SYNC_BIT = 7;
    localparam int GEN_ASYNC_RST_BIT = 1;
    localparam int GEN_SHARED_RST_BIT = 0;
    // port control bits: pin direction and global enable
    localparam int PORT_DIR_BIT = 0;
    localparam int PORT_GIE_BIT = 1;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // counter limits
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // prescaler taps
    localparam int PRESC_W = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    // waveform modes
    typedef enum logic [1:0] {
        TMR8_NORMAL = 2'b00,
        TMR8_PHASE = 2'b01,
        TMR8_CLEAR = 2'b10,
        TMR8_FAST = 2'b11
    } tmr8_wave_t;
    // clock source codes
    typedef enum logic [2:0] {
        TMR8_CS_STOP = 3'b000,
        TMR8_CS_DIV1 = 3'b001,
        TMR8_CS_DIV8 = 3'b010,
        TMR8_CS_DIV64 = 3'b011,
        TMR8_CS_DIV256 = 3'b100,
        TMR8_CS_DIV1024 = 3'b101,
        TMR8_CS_EXT_FALL = 3'b110,
        TMR8_CS_EXT_RISE = 3'b111
    } tmr8_cs_t;
endpackage

/* hdl/tmr8_tick_gen.sv */
// module: prescaler, external pin synchroniser and edge detector making the count enable
`timescale 1ns/100ps
module tmr8_tick_gen (
    input wire logic clock,
    input wire logic resetn,
    input wire logic external_count_pin,
    tmr8_tick_if.src tk
);
    // all state of this module
    typedef struct packed {
        logic [tmr8_pkg::PRESC_W-1:0] presc; // free running prescaler
        logic sync1; // first synchroniser stage
        logic sync2; // second synchroniser stage
        logic pin_prev; // last synchronised level
    } tmr8_tick_state_t;

    tmr8_tick_state_t s_q;
    tmr8_tick_state_t s_d;
    logic tap; // selected prescaler tap

    // next state and tick decode
    always_comb begin
        s_d = s_q;
        s_d.sync1 = external_count_pin;
        s_d.sync2 = s_q.sync1;
        s_d.pin_prev = s_q.sync2;
        // prescaler reset held while requested
        if (tk.presc_hold) begin
            s_d.presc = '0;
        end else begin
            s_d.presc = s_q.presc + 1'b1;
        end
        tap = 1'b0;
        case (tmr8_pkg::tmr8_cs_t'(tk.clock_source_field))
            tmr8_pkg::TMR8_CS_STOP: tap = 1'b0;
            tmr8_pkg::TMR8_CS_DIV1: tap = 1'b1;
            tmr8_pkg::TMR8_CS_DIV8: tap = (s_q.presc & tmr8_pkg::DIV8_MASK) == tmr8_pkg::DIV8_MASK;
            tmr8_pkg::TMR8_CS_DIV64: tap = (s_q.presc & tmr8_pkg::DIV64_MASK) == tmr8_pkg::DIV64_MASK;
            tmr8_pkg::TMR8_CS_DIV256: tap = (s_q.presc & tmr8_pkg::DIV256_MASK) == tmr8_pkg::DIV256_MASK;
            tmr8_pkg::TMR8_CS_DIV1024: tap = s_q.presc == tmr8_pkg::DIV1024_MASK;
            // pin edges count regardless of pin direction
            tmr8_pkg::TMR8_CS_EXT_FALL: tap = s_q.pin_prev & ~s_q.sync2;
            tmr8_pkg::TMR8_CS_EXT_RISE: tap = ~s_q.pin_prev & s_q.sync2;
            default: tap = 1'b0;
        endcase
        // internal taps halted by prescaler hold
        if (tk.presc_hold && tk.clock_source_field != 3'b110 && tk.clock_source_field != 3'b111) begin
            tap = 1'b0;
        end
    end

    assign tk.tick = tap;

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* hdl/tmr8_tick_if.sv */
// interface: timer tick request and prescaler hold between the two modules
`timescale 1ns/100ps
interface tmr8_tick_if;
    logic [2:0] clock_source_field; // selected source
    logic presc_hold; // prescaler held in reset
    logic tick; // one-cycle count enable
    modport src(input clock_source_field, input presc_hold, output tick);
    modport user(output clock_source_field, output presc_hold, input tick);
endinterface

/* hdl/tmr8_top.sv */
// top: 8-bit timer/counter with one compare channel behind an APB slave
// Function
// - mode field: normal, phase, clear, fast
// - compare buffering and overflow point per mode
// - nonzero output action overrides the pin
// - non-PWM: toggle, clear or set on match
// - fast PWM: clear/set on match, opposite at bottom
// - fast PWM compare at top acts at bottom
// - phase PWM: action differs up and down
// - phase PWM compare at top acts at top
// - clock field: stop, direct, prescaled taps
// - codes 110/111 count falling/rising pin edges
// - pin edges count even when pin outputs
// - counter rw; write blocks next match
// - compare register continuously compared with counter
// - compare irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - compare flag set on match, cleared by one
// - overflow flag set on overflow, cleared by one
// - phase PWM overflow at bottom reversal
// - sync mode holds prescaler resets until cleared
// - shared prescaler reset self clears unless sync
// - force strobe applies action in non-PWM modes only, reads zero
`timescale 1ns/100ps
module tmr8_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    output logic waveform_out_pin,
    output logic waveform_out_oe_n,
    output logic port_override,
    output logic compare_irq,
    output logic overflow_irq,
    output logic async_prescaler_reset
);
    // all state of the top
    typedef struct packed {
        logic [1:0] wave_mode_field; // waveform mode
        logic [1:0] output_action_field; // compare output action
        logic [2:0] clock_source_field; // clock select
        logic [7:0] count; // counter
        logic [7:0] cmp_buf; // written compare value
        logic [7:0] cmp_act; // compare value in use
        logic compare_irq_enable; // mask bit 1
        logic overflow_irq_enable; // mask bit 0
        logic compare_match_flag; // sticky compare flag
        logic overflow_flag; // sticky overflow flag
        logic sync_hold_mode; // synchronisation mode
        logic shared_prescaler_reset; // shared prescaler reset
        logic async_prescaler_reset; // sibling prescaler reset
        logic pin_dir; // pin direction, one is output
        logic cpu_status_word_gie; // global interrupt enable
        logic down; // phase mode counting down
        logic wave; // waveform output level
        logic block_match; // counter write blocks next match
        logic [31:0] rdata; // registered read data
    } tmr8_state_t;

    tmr8_state_t s_q;
    tmr8_state_t s_d;
    tmr8_tick_if tk();

    logic wr; // write access phase
    logic rd; // read setup phase
    logic match; // counter equals compare
    logic [7:0] top; // current top
    logic cmp_at_top; // special top case
    logic [7:0] wdat; // written byte
    logic cmp_set; // compare flag set event this cycle
    logic ovf_set; // overflow flag set event this cycle
    tmr8_pkg::tmr8_wave_t mode; // decoded mode

    tmr8_tick_gen u_tick (
        .clock(clock),
        .resetn(resetn),
        .external_count_pin(external_count_pin),
        .tk(tk)
    );

    // prescaler source and hold to the tick generator
    assign tk.clock_source_field = s_q.clock_source_field;
    assign tk.presc_hold = s_q.shared_prescaler_reset;

    // apb decode, zero wait states
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign wdat = pwdata[7:0];

    // unmapped addresses answer with an error
    always_comb begin
        case (paddr)
            tmr8_pkg::ADDR_CTRL_A, tmr8_pkg::ADDR_COUNT, tmr8_pkg::ADDR_COMPARE,
            tmr8_pkg::ADDR_IRQ_MASK, tmr8_pkg::ADDR_IRQ_FLAGS, tmr8_pkg::ADDR_GEN_CTRL,
            tmr8_pkg::ADDR_PORT_CTRL: pslverr = 1'b0;
            default: pslverr = psel & penable;
        endcase
    end

    // main next state
    always_comb begin
        s_d = s_q;
        cmp_set = 1'b0;
        ovf_set = 1'b0;
        mode = tmr8_pkg::tmr8_wave_t'(s_q.wave_mode_field);
        // top is compare only in clear mode
        top = (mode == tmr8_pkg::TMR8_CLEAR) ? s_q.cmp_act : tmr8_pkg::CNT_MAX;
        match = s_q.count == s_q.cmp_act;
        cmp_at_top = s_q.output_action_field[1] && s_q.cmp_act == top;

        // counter step on each tick
        if (tk.tick) begin
            s_d.block_match = 1'b0;
            // compare flag on match unless blocked by a counter write
            if (match && !s_q.block_match) begin
                s_d.compare_match_flag = 1'b1;
                cmp_set = 1'b1;
            end
            case (mode)
                tmr8_pkg::TMR8_NORMAL, tmr8_pkg::TMR8_FAST: begin
                    s_d.count = s_q.count + 8'h01;
                    if (s_q.count == tmr8_pkg::CNT_MAX) begin
                        s_d.overflow_flag = 1'b1;
                        ovf_set = 1'b1;
                    end
                end
                tmr8_pkg::TMR8_CLEAR: begin
                    s_d.count = (s_q.count == top) ? tmr8_pkg::CNT_BOTTOM : s_q.count + 8'h01;
                    if (s_q.count == tmr8_pkg::CNT_MAX) begin
                        s_d.overflow_flag = 1'b1;
                        ovf_set = 1'b1;
                    end
                end
                tmr8_pkg::TMR8_PHASE: begin
                    if (!s_q.down) begin
                        if (s_q.count == top) begin
                            s_d.down = 1'b1;
                            s_d.count = s_q.count - 8'h01;
                        end else begin
                            s_d.count = s_q.count + 8'h01;
                        end
                    end else if (s_q.count == tmr8_pkg::CNT_BOTTOM) begin
                        s_d.down = 1'b0;
                        s_d.count = s_q.count + 8'h01;
                        s_d.overflow_flag = 1'b1;
                        ovf_set = 1'b1;
                    end else begin
                        s_d.count = s_q.count - 8'h01;
                    end
                end
                default: s_d.count = s_q.count;
            endcase

            // compare buffer update points
            if (mode == tmr8_pkg::TMR8_PHASE && !s_q.down && s_q.count == top) begin
                s_d.cmp_act = s_q.cmp_buf;
            end
            if (mode == tmr8_pkg::TMR8_FAST && s_q.count == tmr8_pkg::CNT_MAX) begin
                s_d.cmp_act = s_q.cmp_buf;
            end

            // waveform generation
            case (mode)
                tmr8_pkg::TMR8_NORMAL, tmr8_pkg::TMR8_CLEAR: begin
                    if (match && !s_q.block_match) begin
                        case (s_q.output_action_field)
                            2'b01: s_d.wave = ~s_q.wave;
                            2'b10: s_d.wave = 1'b0;
                            2'b11: s_d.wave = 1'b1;
                            default: s_d.wave = s_q.wave;
                        endcase
                    end
                end
                tmr8_pkg::TMR8_FAST: begin
                    if (s_q.output_action_field[1]) begin
                        // bottom reached next: inverting clears, non-inverting sets
                        if (cmp_at_top) begin
                            if (s_q.count == tmr8_pkg::CNT_MAX) begin
                                s_d.wave = ~s_q.output_action_field[0];
                            end
                        end else if (match && !s_q.block_match) begin
                            s_d.wave = s_q.output_action_field[0];
                        end else if (s_q.count == tmr8_pkg::CNT_MAX) begin
                            s_d.wave = ~s_q.output_action_field[0];
                        end
                    end
                end
                tmr8_pkg::TMR8_PHASE: begin
                    if (s_q.output_action_field[1]) begin
                        if (cmp_at_top) begin
                            if (!s_q.down && s_q.count == top) begin
                                // level at top equals a down-count match result
                                s_d.wave = ~s_q.output_action_field[0];
                            end
                        end else if (match && !s_q.block_match) begin
                            // up-count match: field bit 0; down-count: inverse
                            s_d.wave = s_q.down ? ~s_q.output_action_field[0]
                                                : s_q.output_action_field[0];
                        end
                    end
                end
                default: s_d.wave = s_q.wave;
            endcase
        end

        // hardware clear by vector execution
        if (compare_vector_ack) begin
            s_d.compare_match_flag = 1'b0;
        end
        if (overflow_vector_ack) begin
            s_d.overflow_flag = 1'b0;
        end

        // shared prescaler reset self clears outside sync mode
        if (!s_q.sync_hold_mode) begin
            s_d.shared_prescaler_reset = 1'b0;
            s_d.async_prescaler_reset = 1'b0;
        end

        // register writes
        if (wr) begin
            case (paddr)
                tmr8_pkg::ADDR_CTRL_A: begin
                    s_d.wave_mode_field = {wdat[tmr8_pkg::CTRL_WAVE1_BIT], wdat[tmr8_pkg::CTRL_WAVE0_BIT]};
                    s_d.output_action_field = wdat[tmr8_pkg::CTRL_OUT_LSB +: 2];
                    s_d.clock_source_field = wdat[tmr8_pkg::CTRL_CS_LSB +: 3];
                    // force strobe acts only in non-PWM modes, no flag, no clear
                    if (wdat[tmr8_pkg::CTRL_FORCE_BIT] && !wdat[tmr8_pkg::CTRL_WAVE0_BIT]) begin
                        case (wdat[tmr8_pkg::CTRL_OUT_LSB +: 2])
                            2'b01: s_d.wave = ~s_q.wave;
                            2'b10: s_d.wave = 1'b0;
                            2'b11: s_d.wave = 1'b1;
                            default: s_d.wave = s_q.wave;
                        endcase
                    end
                end
                tmr8_pkg::ADDR_COUNT: begin
                    s_d.count = wdat;
                    s_d.block_match = 1'b1;
                end
                tmr8_pkg::ADDR_COMPARE: begin
                    s_d.cmp_buf = wdat;
                    // immediate in non-PWM modes
                    if (!s_q.wave_mode_field[0]) begin
                        s_d.cmp_act = wdat;
                    end
                end
                tmr8_pkg::ADDR_IRQ_MASK: begin
                    s_d.compare_irq_enable = wdat[tmr8_pkg::FLAG_CMP_BIT];
                    s_d.overflow_irq_enable = wdat[tmr8_pkg::FLAG_OVF_BIT];
                end
                tmr8_pkg::ADDR_IRQ_FLAGS: begin
                    // write one clears, a same-cycle set wins
                    if (wdat[tmr8_pkg::FLAG_CMP_BIT] && !cmp_set) begin
                        s_d.compare_match_flag = 1'b0;
                    end
                    if (wdat[tmr8_pkg::FLAG_OVF_BIT] && !ovf_set) begin
                        s_d.overflow_flag = 1'b0;
                    end
                end
                tmr8_pkg::ADDR_GEN_CTRL: begin
                    s_d.sync_hold_mode = wdat[tmr8_pkg::GEN_SYNC_BIT];
                    // held while sync mode on, cleared by hardware otherwise
                    s_d.shared_prescaler_reset = wdat[tmr8_pkg::GEN_SHARED_RST_BIT];
                    s_d.async_prescaler_reset = wdat[tmr8_pkg::GEN_ASYNC_RST_BIT];
                end
                tmr8_pkg::ADDR_PORT_CTRL: begin
                    s_d.pin_dir = wdat[tmr8_pkg::PORT_DIR_BIT];
                    s_d.cpu_status_word_gie = wdat[tmr8_pkg::PORT_GIE_BIT];
                end
                default: s_d.count = s_d.count;
            endcase
        end

        // read data captured in the setup cycle
        s_d.rdata = '0;
        if (rd) begin
            case (paddr)
                tmr8_pkg::ADDR_CTRL_A: begin
                    // force strobe reads zero
                    s_d.rdata[7:0] = {1'b0, s_q.wave_mode_field[1], s_q.output_action_field,
                                      s_q.wave_mode_field[0], s_q.clock_source_field};
                end
                tmr8_pkg::ADDR_COUNT: s_d.rdata[7:0] = s_q.count;
                tmr8_pkg::ADDR_COMPARE: s_d.rdata[7:0] = s_q.cmp_buf;
                tmr8_pkg::ADDR_IRQ_MASK: s_d.rdata[1:0] = {s_q.compare_irq_enable, s_q.overflow_irq_enable};
                tmr8_pkg::ADDR_IRQ_FLAGS: s_d.rdata[1:0] = {s_q.compare_match_flag, s_q.overflow_flag};
                tmr8_pkg::ADDR_GEN_CTRL: s_d.rdata[7:0] = {s_q.sync_hold_mode, 5'h00,
                                                            s_q.async_prescaler_reset,
                                                            s_q.shared_prescaler_reset};
                tmr8_pkg::ADDR_PORT_CTRL: s_d.rdata[1:0] = {s_q.cpu_status_word_gie, s_q.pin_dir};
                default: s_d.rdata = '0;
            endcase
        end else if (psel && penable) begin
            s_d.rdata = s_q.rdata; // hold through access phase
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign prdata = s_q.rdata;
    assign port_override = s_q.output_action_field != 2'b00;
    assign waveform_out_pin = s_q.wave;
    // driver on only when overriding and direction is output
    assign waveform_out_oe_n = ~(port_override & s_q.pin_dir);
    assign compare_irq = s_q.compare_irq_enable & s_q.cpu_status_word_gie & s_q.compare_match_flag;
    assign overflow_irq = s_q.overflow_irq_enable & s_q.cpu_status_word_gie & s_q.overflow_flag;
    assign async_prescaler_reset = s_q.async_prescaler_reset;
endmodule

/* verif/tb_top.sv */
// testbench: register, counting, waveform and sync checks of the 8-bit timer
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, external_count_pin, waveform_out_pin, waveform_out_oe_n;
    logic compare_vector_ack = 1'b0, overflow_vector_ack = 1'b0, p;
    logic port_override, compare_irq, overflow_irq, async_prescaler_reset;
    int n_mismatch = 0, cmp_count = 0, n;
    logic [7:0] mdl [7] = '{default: 8'h00}; // model of stored register bytes
    tmr8_top i_tmr8_top (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_count_pin, .compare_vector_ack, .overflow_vector_ack,
        .waveform_out_pin, .waveform_out_oe_n, .port_override, .compare_irq, .overflow_irq,
        .async_prescaler_reset);
    tmr8_pin_model i_tmr8_pin_model (.clock, .external_count_pin);
    // clock at 20 MHz
    initial forever #25 clock = ~clock;
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (w && a <= tmr8_pkg::ADDR_PORT_CTRL) mdl[a[4:2]] = d[7:0];
    endtask
    // compare and count
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read a register and compare with the model, force strobe reading zero
    task automatic rdm(input int i);
        apb(1'b0, 12'(i * 4), 32'h0);
        chk("register", {24'h0, (i == 0) ? (mdl[0] & 8'h7F) : mdl[i]}, rd);
    endtask
    // wait for a level under a bound
    task automatic wait_hi(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        #(50 * 6000);
        n_mismatch++;
        summarize();
    end
    // main sequence
    initial begin
        void'($urandom(32'h8E35DD63));
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) rdm(i);
        apb(1'b1, 12'h01C, 32'hFFFFFFFF);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", 33'h100000000, {err, rd});
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, $urandom & 32'h78);
        apb(1'b1, tmr8_pkg::ADDR_COMPARE, $urandom & 32'hFF);
        apb(1'b1, tmr8_pkg::ADDR_COUNT, $urandom & 32'hFF);
        repeat (5) @(posedge clock);
        for (int i = 0; i < 3; i++) rdm(i);
        apb(1'b1, tmr8_pkg::ADDR_PORT_CTRL, 32'h3);
        apb(1'b1, tmr8_pkg::ADDR_IRQ_MASK, 32'h3);
        apb(1'b1, tmr8_pkg::ADDR_COUNT, 32'hF0);
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h01);
        wait_hi(overflow_irq);
        chk("overflow irq", 1'b1, overflow_irq);
        overflow_vector_ack <= 1'b1;
        @(posedge clock);
        overflow_vector_ack <= 1'b0;
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h00);
        apb(1'b1, tmr8_pkg::ADDR_COMPARE, 32'h05);
        apb(1'b1, tmr8_pkg::ADDR_COUNT, 32'h00);
        // stale flags from the free run would satisfy the wait below
        apb(1'b1, tmr8_pkg::ADDR_IRQ_FLAGS, 32'h3);
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h52);
        wait_hi(compare_irq);
        chk("compare irq", 1'b1, compare_irq);
        compare_vector_ack <= 1'b1;
        @(posedge clock);
        compare_vector_ack <= 1'b0;
        apb(1'b0, tmr8_pkg::ADDR_COUNT, 32'h0);
        chk("clear on match", 1'b1, rd[7:0] <= 8'h05);
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h50);
        apb(1'b1, tmr8_pkg::ADDR_IRQ_FLAGS, 32'h3);
        apb(1'b0, tmr8_pkg::ADDR_IRQ_FLAGS, 32'h0);
        chk("flags cleared", 32'h0, rd);
        chk("pin driven", 2'b10, {port_override, waveform_out_oe_n});
        p = waveform_out_pin;
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'hD0);
        chk("force toggle", {~p}, waveform_out_pin);
        rdm(0);
        for (int a = 2; a < 4; a++) begin
            apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h80 | (a << 4));
            chk("force action", a == 3, waveform_out_pin);
        end
        // fast pwm non-inverting: high from bottom up to the compare value
        apb(1'b1, tmr8_pkg::ADDR_COMPARE, 32'h80);
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h69);
        repeat (300 + ($urandom & 32'hFF)) @(posedge clock);
        apb(1'b1, tmr8_pkg::ADDR_CTRL_A, 32'h68);
        apb(1'b0, tmr8_pkg::ADDR_COUNT, 32'h0);
        chk("fast pwm pin", rd[7:0] <= 8'h80, waveform_out_pin);
        for (int e = 7; e > 5; e--) begin
            apb(1'b1, tmr8_pkg::ADDR_CTRL_A, e);
            apb(1'b1, tmr8_pkg::ADDR_COUNT, 32'h0);
            i_tmr8_pin_model.pulse(e - 2);
            repeat (6) @(posedge clock);
            apb(1'b0, tmr8_pkg::ADDR_COUNT, 32'h0);
            chk("pin count", e - 2, rd);
        end
        apb(1'b1, tmr8_pkg::ADDR_GEN_CTRL, 32'h83);
        apb(1'b0, tmr8_pkg::ADDR_GEN_CTRL, 32'h0);
        chk("sync hold", 33'h100000083, {async_prescaler_reset, rd});
        // resets written high with sync off must be dropped by hardware
        apb(1'b1, tmr8_pkg::ADDR_GEN_CTRL, 32'h03);
        apb(1'b0, tmr8_pkg::ADDR_GEN_CTRL, 32'h0);
        chk("sync release", 33'h0, {async_prescaler_reset, rd});
        apb(1'b1, tmr8_pkg::ADDR_GEN_CTRL, 32'h01);
        apb(1'b0, tmr8_pkg::ADDR_GEN_CTRL, 32'h0);
        chk("self clear", 32'h0, rd);
        summarize();
    end
endmodule
bind tmr8_top tmr8_properties i_tmr8_properties (.clock, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .external_count_pin, .compare_vector_ack,
    .overflow_vector_ack, .waveform_out_pin, .waveform_out_oe_n, .port_override,
    .compare_irq, .overflow_irq, .async_prescaler_reset);

/* verif/tmr8_pin_model.sv */
// partner: source of the external count pin, idle low between bursts
`timescale 1ns/100ps
module tmr8_pin_model (
    input wire logic clock,
    output logic external_count_pin
);
    initial external_count_pin = 1'b0; // idle level
    // one rise and one fall per pulse, levels long enough to be sampled
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            external_count_pin <= 1'b1;
            repeat (3) @(posedge clock);
            external_count_pin <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
endmodule

/* verif/tmr8_properties.sv */
// checker: port-level properties of the 8-bit timer
`timescale 1ns/100ps
module tmr8_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_count_pin,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    input wire logic waveform_out_pin,
    input wire logic waveform_out_oe_n,
    input wire logic port_override,
    input wire logic compare_irq,
    input wire logic overflow_irq,
    input wire logic async_prescaler_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic rd_acc; // read access phase
    assign rd_acc = psel && penable && !pwrite;
    chk_oe_needs_override: assert property (!waveform_out_oe_n |-> port_override)
        else $error("pin driver enabled without override");
    chk_override_field: assert property (rd_acc && paddr == tmr8_pkg::ADDR_CTRL_A |->
        port_override == (prdata[5:4] != 2'b00))
        else $error("override does not follow action field");
    chk_force_reads_zero: assert property (rd_acc && paddr == tmr8_pkg::ADDR_CTRL_A |->
        !prdata[7])
        else $error("force strobe read as one");
    chk_dir_gates_drv: assert property (rd_acc && paddr == tmr8_pkg::ADDR_PORT_CTRL &&
        !prdata[0] |-> waveform_out_oe_n)
        else $error("driver enabled with input direction");
    chk_cmp_irq_mask: assert property (rd_acc && paddr == tmr8_pkg::ADDR_IRQ_MASK &&
        !prdata[1] |-> !compare_irq)
        else $error("compare irq while masked");
    chk_ovf_irq_mask: assert property (rd_acc && paddr == tmr8_pkg::ADDR_IRQ_MASK &&
        !prdata[0] |-> !overflow_irq)
        else $error("overflow irq while masked");
    chk_gie_gates_irq: assert property (rd_acc &&
        paddr == tmr8_pkg::ADDR_PORT_CTRL && !prdata[1] |-> !compare_irq && !overflow_irq)
        else $error("irq without global enable");
    chk_cmp_ack_clear: assert property (compare_vector_ack |=> !compare_irq)
        else $error("compare irq survives vector ack");
    chk_ovf_ack_clear: assert property (overflow_vector_ack |=> !overflow_irq)
        else $error("overflow irq survives vector ack");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h018 |->
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule
